//--- core/pip_pkg.sv
// Purpose: Shared constants for the eight-channel PTC input process image block
// Assumes: Plain register port, 8-bit data, one clock
// Notes: Offsets are word indices on the local register port
package pip_pkg;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;
    // Register offsets
    localparam logic [3:0] OFS_IN_BYTE_ZERO = 4'h0;
    localparam logic [3:0] OFS_IN_BYTE_ONE = 4'h1;
    localparam logic [3:0] OFS_OUT_BYTE_ZERO = 4'h2;
    localparam logic [3:0] OFS_OUT_BYTE_ONE = 4'h3;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h5;
    localparam logic [3:0] OFS_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] OFS_IMAGE_SIZE = 4'h7;
    // Reset values and fixed contents
    localparam logic [7:0] RST_DISABLE = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RSVD_BYTE = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;
    // Image size: input bytes in low nibble, output bytes in high nibble
    localparam logic [7:0] IMAGE_SIZE = 8'h22;
    // Interrupt status layout
    localparam int unsigned IRQ_FAULT_RISE = 0;
    localparam int unsigned IRQ_STATE_CHANGE = 1;
    localparam int unsigned IRQ_RSVD_WRITE = 2;
    localparam int unsigned IRQ_W = 3;
endpackage : pip_pkg

//--- core/pip_sync.sv
// Purpose: Two-flop synchroniser for a bus of pin levels
// Assumes: Inputs are asynchronous to mclk
// Notes: First stage feeds only the second
`timescale 1ns/10ps
module pip_sync #(
    parameter int unsigned W = 8
) (
    input wire logic mclk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [W-1:0] d_async, // Raw pin levels
    output logic [W-1:0] q_sync // Synchronised levels
);
    logic [W-1:0] meta;

    // Two stages, reset to zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta <= '0;
            q_sync <= '0;
        end else begin
            meta <= d_async;
            q_sync <= meta;
        end
    end
endmodule : pip_sync

//--- core/pip_chan.sv
// Purpose: Per-channel state and fault qualification
// Assumes: Inputs already synchronised
// Notes: A disabled channel reports zero state and no fault
`timescale 1ns/10ps
module pip_chan (
    input wire logic mclk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic level, // Synchronised input level
    input wire logic fault, // Synchronised wire-break/short flag
    input wire logic disable_bit, // Set switches channel off
    output logic state, // Registered signal state
    output logic flt // Registered fault flag
);
    // Gate both with the channel switch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= 1'b0;
            flt <= 1'b0;
        end else begin
            state <= level & ~disable_bit;
            flt <= fault & ~disable_bit;
        end
    end
endmodule : pip_chan

//--- core/pip_image.sv
// Purpose: Process image of an eight-channel PTC input module with diagnostics
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Interrupt block flags fault onsets, state changes and bad reserved writes
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// RULE1: Eight channels, two input bytes and two output bytes in the image.
// RULE2: Input byte zero holds channel states, channel n on bit n-1.
// RULE3: Input byte one holds per-channel wire-break or short-circuit fault flags.
// RULE4: Controller writes output byte one; module applies each channel setting.
// RULE5: Controller keeps output byte zero all zero; module ignores it.
// RULE6: Output byte one bit n-1: clear keeps channel on, set switches off.
module pip_image (
    input wire logic mclk, // System clock, 25 MHz
    input wire logic rst, // Async reset, active high
    input wire logic [7:0] ch_level, // Raw channel levels from sensing
    input wire logic [7:0] ch_fault, // Raw wire-break/short flags
    input wire logic [3:0] reg_addr, // Register index
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    output logic [7:0] ch_off, // Applied channel-off controls
    output logic irq // Level interrupt
);
    // Channel image, history and interrupt state
    logic [7:0] level_s;
    logic [7:0] fault_s;
    logic [7:0] state_q;
    logic [7:0] flt_q;
    logic [7:0] flt_prev;
    logic [7:0] state_prev;
    logic [7:0] out_byte_one;
    logic [pip_pkg::IRQ_W-1:0] irq_status;
    logic [pip_pkg::IRQ_W-1:0] irq_enable;
    logic [pip_pkg::IRQ_W-1:0] irq_event;
    logic [pip_pkg::IRQ_W-1:0] irq_clr;
    logic [7:0] next_rdata;

    // Pins cross into mclk
    // Pin to input byte takes two synchroniser edges plus the channel
    // register, so a pin change is readable from the third edge on.
    // The channel register also applies the off switch, which keeps a
    // switched-off channel from raising fault events; only its drop from a high state to zero raises a change event.
    pip_sync #(.W(pip_pkg::NUM_CH)) u_sync_level (
        .mclk(mclk),
        .rst(rst),
        .d_async(ch_level),
        .q_sync(level_s)
    );
    pip_sync #(.W(pip_pkg::NUM_CH)) u_sync_fault (
        .mclk(mclk),
        .rst(rst),
        .d_async(ch_fault),
        .q_sync(fault_s)
    );

    // One qualifier per channel, channel n on bit n-1
    generate
        for (genvar i = 0; i < pip_pkg::NUM_CH; i++) begin : g_ch
            pip_chan u_chan (
                .mclk(mclk),
                .rst(rst),
                .level(level_s[i]), // RULE2
                .fault(fault_s[i]), // RULE3
                .disable_bit(out_byte_one[i]), // RULE6
                .state(state_q[i]),
                .flt(flt_q[i])
            );

            // Each channel follows its own pins while switched on
            AST_CH_STATE: assert property (@(posedge mclk) disable iff (rst) // RULE2
                !out_byte_one[i] |=> state_q[i] == $past(level_s[i]))
                else $error("channel state does not follow its pin");

            AST_CH_FAULT: assert property (@(posedge mclk) disable iff (rst) // RULE3
                !out_byte_one[i] |=> flt_q[i] == $past(fault_s[i]))
                else $error("channel fault does not follow its pin");

            // A set control bit silences the channel from the next edge on
            AST_CH_SILENT: assert property (@(posedge mclk) disable iff (rst) // RULE6
                out_byte_one[i] |=> !state_q[i] && !flt_q[i])
                else $error("switched-off channel still reports");
        end
    endgenerate

    // Output byte one, channel-off controls; byte zero has no storage
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_byte_one <= pip_pkg::RST_DISABLE;
        end else if (reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ONE) begin
            out_byte_one <= reg_wdata; // RULE4
        end
    end

    // Applied controls mirrored to pins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ch_off <= pip_pkg::RST_DISABLE;
        end else begin
            ch_off <= out_byte_one; // RULE4
        end
    end

    // History for edge events
    // Resets to the channel registers' idle level, so no false edge follows reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flt_prev <= pip_pkg::RST_ZERO;
            state_prev <= pip_pkg::RST_ZERO;
        end else begin
            flt_prev <= flt_q;
            state_prev <= state_q;
        end
    end

    // Events; a nonzero write to reserved byte is flagged for software
    always_comb begin
        irq_event = '0;
        irq_event[pip_pkg::IRQ_FAULT_RISE] = |(flt_q & ~flt_prev);
        irq_event[pip_pkg::IRQ_STATE_CHANGE] = |(state_q ^ state_prev);
        irq_event[pip_pkg::IRQ_RSVD_WRITE] = reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ZERO
            && reg_wdata != pip_pkg::RSVD_BYTE; // RULE5
    end

    // Clear strobes, one per status bit, live only in the write cycle
    assign irq_clr = (reg_wr && reg_addr == pip_pkg::OFS_IRQ_CLEAR) ? reg_wdata[pip_pkg::IRQ_W-1:0] : '0;

    // Sticky status; a set in the clear cycle wins
    // Trade-off: software may see a bit survive its clear, but never loses an event
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_event;
        end
    end

    // Interrupt enables
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_enable <= '0;
        end else if (reg_wr && reg_addr == pip_pkg::OFS_IRQ_ENABLE) begin
            irq_enable <= reg_wdata[pip_pkg::IRQ_W-1:0];
        end
    end

    // Registered interrupt, one cycle behind status
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_enable);
        end
    end

    // Register map, one byte per index:
    //   0 input byte zero, channel states, read only
    //   1 input byte one, channel fault flags, read only
    //   2 output byte zero, reserved, reads zero, writes dropped
    //   3 output byte one, channel-off controls, read and write
    //   4 interrupt status, sticky, read only
    //   5 interrupt clear, write ones to clear, reads zero
    //   6 interrupt enable, read and write
    //   7 image size, input bytes low nibble, output bytes high
    //   8 to 15 unmapped, read zero
    // Read mux; the image is two bytes each way
    always_comb begin
        next_rdata = pip_pkg::UNMAPPED_DATA;
        unique case (reg_addr)
            pip_pkg::OFS_IN_BYTE_ZERO: next_rdata = state_q; // RULE2
            pip_pkg::OFS_IN_BYTE_ONE: next_rdata = flt_q; // RULE3
            pip_pkg::OFS_OUT_BYTE_ZERO: next_rdata = pip_pkg::RSVD_BYTE; // RULE5
            pip_pkg::OFS_OUT_BYTE_ONE: next_rdata = out_byte_one; // RULE6
            pip_pkg::OFS_IRQ_STATUS: next_rdata = {{(8 - pip_pkg::IRQ_W){1'b0}}, irq_status};
            pip_pkg::OFS_IRQ_ENABLE: next_rdata = {{(8 - pip_pkg::IRQ_W){1'b0}}, irq_enable};
            pip_pkg::OFS_IMAGE_SIZE: next_rdata = pip_pkg::IMAGE_SIZE; // RULE1
            default: next_rdata = pip_pkg::UNMAPPED_DATA;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    // Zero between reads keeps stale image bytes off the port
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= pip_pkg::UNMAPPED_DATA;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= pip_pkg::UNMAPPED_DATA;
        end
    end

    // Checks
    // Bus-side sequences first, then the events the status register latches
    sequence s_write_off;
        reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ONE;
    endsequence

    sequence s_read_in_one;
        reg_rd && reg_addr == pip_pkg::OFS_IN_BYTE_ONE;
    endsequence

    sequence s_read_out_one;
        reg_rd && reg_addr == pip_pkg::OFS_OUT_BYTE_ONE;
    endsequence

    // Events as the status register sees them at an edge
    sequence s_fault_onset;
        (flt_q & ~flt_prev) != pip_pkg::RST_ZERO;
    endsequence

    sequence s_state_change;
        state_q != state_prev;
    endsequence

    sequence s_rsvd_write;
        reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ZERO && reg_wdata != pip_pkg::RSVD_BYTE;
    endsequence

    AST_OFF_APPLIED: assert property (@(posedge mclk) disable iff (rst) // RULE4
        s_write_off |=> ##1 (ch_off == $past(reg_wdata, 2)))
        else $error("channel-off byte not applied");

    AST_OFF_MASKS: assert property (@(posedge mclk) disable iff (rst) // RULE6
        out_byte_one[0] |=> !state_q[0] && !flt_q[0])
        else $error("disabled channel still reports");

    AST_STATE_FOLLOWS: assert property (@(posedge mclk) disable iff (rst) // RULE2
        !out_byte_one[7] |=> state_q[7] == $past(level_s[7]))
        else $error("state bit 7 does not follow channel 8");

    AST_FAULT_FOLLOWS: assert property (@(posedge mclk) disable iff (rst) // RULE3
        !out_byte_one[0] |=> flt_q[0] == $past(fault_s[0]))
        else $error("fault bit 0 does not follow channel 1");

    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (rst) // RULE5
        reg_rd && reg_addr == pip_pkg::OFS_OUT_BYTE_ZERO |=> reg_rdata == pip_pkg::RSVD_BYTE)
        else $error("reserved byte reads nonzero");

    AST_READ_IN0: assert property (@(posedge mclk) disable iff (rst) // RULE2
        reg_rd && reg_addr == pip_pkg::OFS_IN_BYTE_ZERO |=> reg_rdata == $past(state_q))
        else $error("input byte zero read wrong");

    AST_SIZE: assert property (@(posedge mclk) disable iff (rst) // RULE1
        reg_rd && reg_addr == pip_pkg::OFS_IMAGE_SIZE |=> reg_rdata == pip_pkg::IMAGE_SIZE)
        else $error("image size read wrong");

    AST_RSVD_IGNORED: assert property (@(posedge mclk) disable iff (rst) // RULE5
        reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ZERO |=> $stable(out_byte_one))
        else $error("reserved write changed controls");

    // Each readable byte shows the value from the strobe's edge
    AST_READ_IN1: assert property (@(posedge mclk) disable iff (rst) // RULE3
        s_read_in_one |=> reg_rdata == $past(flt_q))
        else $error("input byte one read wrong");

    AST_READ_OUT1: assert property (@(posedge mclk) disable iff (rst) // RULE6
        s_read_out_one |=> reg_rdata == $past(out_byte_one))
        else $error("output byte one read wrong");

    // Read data is zero outside the cycle after a read strobe
    AST_RDATA_IDLE: assert property (@(posedge mclk) disable iff (rst) // RULE1
        !reg_rd |=> reg_rdata == pip_pkg::UNMAPPED_DATA)
        else $error("read data left on the port");

    // Unmapped and write-only indices read zero
    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (rst) // RULE1
        reg_rd && (reg_addr > pip_pkg::OFS_IMAGE_SIZE || reg_addr == pip_pkg::OFS_IRQ_CLEAR) |=> reg_rdata == '0)
        else $error("unmapped index read nonzero");

    // Controls move only on a write to output byte one
    AST_OFF_HELD: assert property (@(posedge mclk) disable iff (rst) // RULE4
        !(reg_wr && reg_addr == pip_pkg::OFS_OUT_BYTE_ONE) |=> $stable(out_byte_one))
        else $error("channel-off byte changed without a write");

    // Pins carry the byte one edge after it is stored
    AST_OFF_MIRROR: assert property (@(posedge mclk) disable iff (rst) // RULE4
        1'b1 |=> ch_off == $past(out_byte_one))
        else $error("channel-off pins lag the byte");

    // Status bits are set on their events even in a clear cycle
    AST_FAULT_STICKY: assert property (@(posedge mclk) disable iff (rst) // RULE3
        s_fault_onset |=> irq_status[pip_pkg::IRQ_FAULT_RISE])
        else $error("fault onset not latched");

    AST_STATE_EVENT: assert property (@(posedge mclk) disable iff (rst) // RULE2
        s_state_change |=> irq_status[pip_pkg::IRQ_STATE_CHANGE])
        else $error("state change not latched");

    AST_RSVD_FLAGGED: assert property (@(posedge mclk) disable iff (rst) // RULE5
        s_rsvd_write |=> irq_status[pip_pkg::IRQ_RSVD_WRITE])
        else $error("nonzero reserved write not flagged");

    // A clear with no new onset empties the fault bit
    AST_CLEAR_FAULT: assert property (@(posedge mclk) disable iff (rst) // RULE3
        reg_wr && reg_addr == pip_pkg::OFS_IRQ_CLEAR && reg_wdata[pip_pkg::IRQ_FAULT_RISE]
            && (flt_q & ~flt_prev) == pip_pkg::RST_ZERO |=> !irq_status[pip_pkg::IRQ_FAULT_RISE])
        else $error("fault bit survived its clear");

    // Interrupt is the enabled status one edge later
    AST_IRQ_RAISE: assert property (@(posedge mclk) disable iff (rst) // RULE3
        (irq_status & irq_enable) != '0 |=> irq)
        else $error("enabled status did not raise the interrupt");

    AST_IRQ_DROP: assert property (@(posedge mclk) disable iff (rst) // RULE3
        (irq_status & irq_enable) == '0 |=> !irq)
        else $error("interrupt high with no enabled status");
endmodule : pip_image

//--- dv/pip_ctrl_model.sv
// Purpose: Controller model that drives the process-image register port
// Assumes: Read data stands only in the cycle after the read strobe
// Notes: Write data released as the inverse of its last value
`timescale 1ns/10ps
module pip_ctrl_model (
    input wire logic mclk, // System clock
    output logic [3:0] reg_addr, // Register index
    output logic [7:0] reg_wdata, // Write data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    input wire logic [7:0] reg_rdata // Read data
);
    // Idle bus from time zero, reserved byte image held at zero
    initial begin
        reg_addr = pip_pkg::OFS_OUT_BYTE_ZERO;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One-cycle write; stale data never left on the bus
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask : wr
    // One-cycle read; data taken in the following cycle only
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd
endmodule : pip_ctrl_model

//--- dv/pip_image_tb_top.sv
// Purpose: Self-checking bench for the process image block
// Assumes: Pin changes visible three edges later, irq one cycle behind status
// Notes: Register traffic goes through the controller model
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pip_image_tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ch_level = 8'h00;
    logic [7:0] ch_fault = 8'h00;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, ch_off, d;
    logic reg_wr, reg_rd, irq;
    int n_errors = 0;
    int checks = 0;
    logic [7:0] exp_rst [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h00};
    // Clock, 40 ns period
    always #20 mclk = ~mclk;
    pip_image u_pip_image (.mclk(mclk), .rst(rst), .ch_level(ch_level), .ch_fault(ch_fault),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ch_off(ch_off), .irq(irq));
    pip_ctrl_model u_pip_ctrl_model (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // Drive pins, then wait past the synchroniser and channel stage
    task automatic pins(input logic [7:0] lv, input logic [7:0] ft);
        @(posedge mclk);
        ch_level <= lv;
        ch_fault <= ft;
        repeat (4) @(posedge mclk);
    endtask : pins
    // Reset contents of every index, plus one unmapped index
    task automatic t_reset_map;
        for (int i = 0; i < 9; i++) begin
            u_pip_ctrl_model.rd(4'(i), d);
            `CHK(d, exp_rst[i])
        end
    endtask : t_reset_map
    // Walk each channel through both input bytes
    task automatic t_walk;
        for (int c = 0; c < 8; c++) begin
            pins(8'h01 << c, 8'h80 >> c);
            u_pip_ctrl_model.rd(pip_pkg::OFS_IN_BYTE_ZERO, d);
            `CHK(d, 8'h01 << c)
            u_pip_ctrl_model.rd(pip_pkg::OFS_IN_BYTE_ONE, d);
            `CHK(d, 8'h80 >> c)
        end
    endtask : t_walk
    // Set bits switch channels off, clear bits keep them on
    task automatic t_disable;
        pins(8'hFF, 8'hFF);
        u_pip_ctrl_model.wr(pip_pkg::OFS_OUT_BYTE_ONE, 8'hA5);
        repeat (4) @(posedge mclk);
        `CHK(ch_off, 8'hA5)
        u_pip_ctrl_model.rd(pip_pkg::OFS_OUT_BYTE_ONE, d);
        `CHK(d, 8'hA5)
        u_pip_ctrl_model.rd(pip_pkg::OFS_IN_BYTE_ZERO, d);
        `CHK(d, 8'h5A)
        u_pip_ctrl_model.rd(pip_pkg::OFS_IN_BYTE_ONE, d);
        `CHK(d, 8'h5A)
        u_pip_ctrl_model.wr(pip_pkg::OFS_OUT_BYTE_ONE, 8'h00);
    endtask : t_disable
    // Reserved byte refused and flagged; irq masked, raised, cleared
    task automatic t_reserved_irq;
        pins(8'h00, 8'h00);
        u_pip_ctrl_model.rd(pip_pkg::OFS_IRQ_STATUS, d);
        `CHK(d, 8'h03)
        u_pip_ctrl_model.wr(pip_pkg::OFS_IRQ_CLEAR, 8'h07);
        u_pip_ctrl_model.wr(pip_pkg::OFS_IRQ_ENABLE, 8'h04);
        u_pip_ctrl_model.wr(pip_pkg::OFS_OUT_BYTE_ZERO, 8'h3C);
        u_pip_ctrl_model.rd(pip_pkg::OFS_OUT_BYTE_ZERO, d);
        `CHK(d, 8'h00)
        u_pip_ctrl_model.rd(pip_pkg::OFS_IRQ_STATUS, d);
        `CHK(d, 8'h04)
        `CHK(irq, 1'b1)
        `CHK(ch_off, 8'h00)
        u_pip_ctrl_model.wr(pip_pkg::OFS_IRQ_ENABLE, 8'h01);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        pins(8'h00, 8'h10);
        repeat (2) @(posedge mclk);
        `CHK(irq, 1'b1)
        u_pip_ctrl_model.wr(pip_pkg::OFS_IRQ_CLEAR, 8'h07);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        u_pip_ctrl_model.rd(pip_pkg::OFS_IRQ_STATUS, d);
        `CHK(d, 8'h00)
    endtask : t_reserved_irq
    // Counts, verdict and end of run
    task automatic conclude;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_reset_map();
        t_walk();
        t_disable();
        t_reserved_irq();
        conclude();
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #(40 * 20000);
        n_errors++;
        conclude();
    end
endmodule : pip_image_tb_top
